// ===== rtl/lcdet_top.sv
`timescale 1ns/1ps
// Remote capability flags and reverse-channel link detect
module lcdet_top #(
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_162US = lcdet_pkg::CYC_162US,
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_325US = lcdet_pkg::CYC_325US,
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_650US = lcdet_pkg::CYC_650US,
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_1MS3  = lcdet_pkg::CYC_1MS3,
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_20US  = lcdet_pkg::CYC_20US,
    parameter logic [lcdet_pkg::CNT_W-1:0] CYC_82US  = lcdet_pkg::CYC_82US
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // Decoded serial control bus access
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    output logic                               reg_rvalid,
    // Control channel
    input  wire logic                          rx_lock,
    input  wire logic                          cap_load_valid,
    input  wire logic [lcdet_pkg::LOAD_W-1:0]  cap_load_bits,
    input  wire logic                          rev_valid,
    // Capability and link outputs
    output logic                               capability_hold,
    output logic                               frequency_pattern_request,
    output logic                               equalizer_pattern_request,
    output logic                               two_lane_capable,
    output logic                               lane_is_secondary,
    output logic                               wide_video_with_hd_audio,
    output logic                               forward_frame_gpio_capable,
    output logic                               link_detect
);

    // Timeout select to cycle count
    function automatic logic [lcdet_pkg::CNT_W-1:0] sel_limit(input logic [2:0] sel);
        case (sel)
            lcdet_pkg::SEL_325US: sel_limit = CYC_325US;  // RULE9
            lcdet_pkg::SEL_650US: sel_limit = CYC_650US;
            lcdet_pkg::SEL_1MS3:  sel_limit = CYC_1MS3;
            lcdet_pkg::SEL_10US:  sel_limit = lcdet_pkg::CYC_10US;
            lcdet_pkg::SEL_20US:  sel_limit = CYC_20US;
            lcdet_pkg::SEL_82US:  sel_limit = CYC_82US;
            default:              sel_limit = CYC_162US;  // RULE13
        endcase
    endfunction

    logic [7:0]                    caps_q;
    logic [7:0]                    caps_d;
    logic [2:0]                    tmo_sel_q;
    logic [2:0]                    tmo_sel_d;
    logic                          link_q;
    logic                          link_d;
    logic [7:0]                    rdata_q;
    logic [7:0]                    rdata_d;
    logic                          rvalid_q;
    logic                          wr_caps;
    logic                          wr_tmo;
    logic                          load_ok;
    logic                          expired;
    logic [lcdet_pkg::CNT_W-1:0]   limit;

    assign wr_caps = reg_wr && (reg_addr == lcdet_pkg::ADDR_CAPS);
    assign wr_tmo  = reg_wr && (reg_addr == lcdet_pkg::ADDR_TIMEOUT);
    assign limit   = sel_limit(tmo_sel_q);

    // Auto-load only while locked and not frozen; a write setting hold also blocks it
    assign load_ok = rx_lock && cap_load_valid && !caps_q[lcdet_pkg::BIT_HOLD]
                     && !(wr_caps && reg_wdata[lcdet_pkg::BIT_HOLD]);  // RULE1 RULE11

    // Capability and timeout register next values
    always_comb begin
        caps_d    = caps_q;
        tmo_sel_d = tmo_sel_q;
        if (wr_caps) begin
            caps_d = reg_wdata & lcdet_pkg::CAPS_WR_MASK;  // RULE3 RULE10
        end
        // Channel load beats a plain write in the same cycle
        if (load_ok) begin
            caps_d[lcdet_pkg::LOAD_W-1:0] = cap_load_bits;  // RULE1 RULE4 RULE12
        end
        if (wr_tmo) begin
            tmo_sel_d = reg_wdata[2:0];  // RULE10
        end
    end

    // Link detect: traffic raises it, an expired quiet period drops it
    always_comb begin
        link_d = link_q;
        if (rev_valid) begin
            link_d = 1'b1;
        end else if (expired) begin
            link_d = 1'b0;  // RULE8
        end
    end

    // Read data; reserved register and bits read as zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            lcdet_pkg::ADDR_CAPS:    rdata_d = caps_q;
            lcdet_pkg::ADDR_TIMEOUT: rdata_d = {5'h00, tmo_sel_q};
            default:                 rdata_d = 8'h00;  // RULE10
        endcase
        if (!reg_rd) begin
            rdata_d = 8'h00;
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            caps_q    <= lcdet_pkg::CAPS_RESET;
            tmo_sel_q <= lcdet_pkg::TIMEOUT_RESET;
            link_q    <= 1'b0;
            rdata_q   <= 8'h00;
            rvalid_q  <= 1'b0;
        end else begin
            caps_q    <= caps_d;
            tmo_sel_q <= tmo_sel_d;
            link_q    <= link_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= reg_rd;
        end
    end

    // Quiet timer runs only while the link is up
    lcdet_timer u_timer (
        .clock   (clock),
        .rst_n   (rst_n),
        .limit   (limit),
        .run     (link_q),
        .restart (rev_valid),
        .expired (expired)
    );

    // Outputs straight from flops
    assign reg_rdata                  = rdata_q;
    assign reg_rvalid                 = rvalid_q;
    assign capability_hold            = caps_q[lcdet_pkg::BIT_HOLD];
    assign frequency_pattern_request  = caps_q[lcdet_pkg::BIT_FREQ];
    assign equalizer_pattern_request  = caps_q[lcdet_pkg::BIT_EQ];   // RULE3
    assign two_lane_capable           = caps_q[lcdet_pkg::BIT_TWO];
    assign lane_is_secondary          = caps_q[lcdet_pkg::BIT_CHAN]; // RULE5
    assign wide_video_with_hd_audio   = caps_q[lcdet_pkg::BIT_WIDE]; // RULE6
    assign forward_frame_gpio_capable = caps_q[lcdet_pkg::BIT_GPIO]; // RULE7
    assign link_detect                = link_q;

    // Helper: cycles since the last reverse-channel traffic
    logic [lcdet_pkg::CNT_W-1:0] quiet_q;
    logic [lcdet_pkg::CNT_W-1:0] quiet_d;

    always_comb begin
        quiet_d = quiet_q + lcdet_pkg::CNT_W'(1);
        if (rev_valid) begin
            quiet_d = '0;
        end else if (&quiet_q) begin
            quiet_d = quiet_q;
        end
    end

    // Saturating register so a long quiet spell cannot wrap back to a small count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            quiet_q <= '0;
        end else begin
            quiet_q <= quiet_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Assertions
    a_load_caps: assert property (load_ok |=>  // RULE1
        caps_q[5:0] == $past(cap_load_bits)) else $error("capability load missed");
    a_hold_freeze: assert property (caps_q[7] && !wr_caps |=>  // RULE11
        $stable(caps_q)) else $error("frozen capabilities changed");
    a_write_eq: assert property (wr_caps && !load_ok |=>  // RULE3
        equalizer_pattern_request == $past(reg_wdata[4])) else $error("eq bit not written");
    a_load_two: assert property (load_ok |=>  // RULE4
        two_lane_capable == $past(cap_load_bits[3])) else $error("two lane bit wrong");
    a_load_chan: assert property (load_ok |=>  // RULE5
        lane_is_secondary == $past(cap_load_bits[2])) else $error("lane index wrong");
    a_load_wide: assert property (load_ok |=>  // RULE6
        wide_video_with_hd_audio == $past(cap_load_bits[1])) else $error("video bit wrong");
    a_load_gpio: assert property (load_ok |=>  // RULE7
        forward_frame_gpio_capable == $past(cap_load_bits[0])) else $error("gpio bit wrong");
    a_load_freq: assert property (load_ok |=>  // RULE12
        frequency_pattern_request == $past(cap_load_bits[5])) else $error("freq bit wrong");
    a_rsvd_read: assert property (reg_rd && reg_addr == lcdet_pkg::ADDR_CAPS_2 |=>  // RULE10
        reg_rvalid && reg_rdata == 8'h00) else $error("reserved register not zero");
    a_link_drop: assert property ($fell(link_q) |->  // RULE8
        quiet_q == $past(limit)) else $error("link dropped at wrong time");
    a_timeout_map: assert property (tmo_sel_q == lcdet_pkg::SEL_10US |->  // RULE9
        limit == lcdet_pkg::CYC_10US) else $error("10.25 us code misdecoded");
    a_rsvd_code: assert property (tmo_sel_q == lcdet_pkg::SEL_RSVD |->  // RULE13
        limit == CYC_162US) else $error("code 110 not default");
    a_hold_write: assert property (wr_caps && reg_wdata[7] |=>  // RULE11
        capability_hold && caps_q[5:0] == $past(reg_wdata[5:0])) else $error("hold write lost");
    a_no_lock_load: assert property (!rx_lock && !wr_caps |=>  // RULE1
        $stable(caps_q)) else $error("capabilities changed without lock");
    a_tmo_write: assert property (wr_tmo |=>  // RULE9
        tmo_sel_q == $past(reg_wdata[2:0])) else $error("timeout select not written");
    a_rsvd_bit6: assert property (wr_caps |=>  // RULE10
        caps_q[6] == 1'b0) else $error("reserved capability bit set");
    a_link_rise: assert property (rev_valid |=>  // RULE8
        link_detect) else $error("link detect not raised by traffic");
    a_lane_written: assert property (wr_caps && !load_ok |=>  // RULE5
        lane_is_secondary == $past(reg_wdata[2])) else $error("lane bit not written");

    // Coverage of main scenarios
    c_load: cover property (load_ok ##1 caps_q[5:0] != 6'h00);
    c_hold_block: cover property (caps_q[7] && rx_lock && cap_load_valid);
    c_link_drop: cover property ($fell(link_q));
    c_restart: cover property (link_q && rev_valid);
    c_hold_write: cover property (wr_caps && reg_wdata[7]);

endmodule // lcdet_top

// ===== rtl/lcdet_pkg.sv
// Operation
// RULE1: After receiver lock, control channel loads capability bits into the first register.
// RULE2: Software overriding capability bits must also set the hold bit.
// RULE3: Bit 4 requests the equalizer training pattern; read/write, resets to zero.
// RULE4: Bit 3 records two-lane support; read/write, loaded after lock.
// RULE5: Bit 2 names this lane: zero primary, one secondary.
// RULE6: Bit 1 says receiver takes 24-bit video with HD audio together.
// RULE7: Bit 0 says receiver supports GPIO inside the forward frame.
// RULE8: Link detect drops when timeout passes with no valid reverse traffic.
// RULE9: Timeout select maps 000..111 to 162,325,650,1300,10.25,20.5,-,82 us.
// RULE10: Second capability register and upper five timeout bits are reserved.
// RULE11: Hold bit 7 stops automatic loading and freezes written capabilities.
// RULE12: Bit 5 requests the frequency training pattern, loaded like the others.
// RULE13: Timeout code 110 behaves as the default 162 us timeout.
package lcdet_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CAPS    = 8'h20;
    localparam logic [7:0] ADDR_CAPS_2  = 8'h21;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h26;

    // Reset values and masks
    localparam logic [7:0] CAPS_RESET    = 8'h00;
    localparam logic [2:0] TIMEOUT_RESET = 3'h0;
    localparam logic [7:0] CAPS_WR_MASK  = 8'hBF;    // Bit 6 reserved
    localparam int         LOAD_W        = 6;        // Bits 5:0 are auto-loaded

    // Field positions in the capability register
    localparam int BIT_HOLD = 7;
    localparam int BIT_FREQ = 5;
    localparam int BIT_EQ   = 4;
    localparam int BIT_TWO  = 3;
    localparam int BIT_CHAN = 2;
    localparam int BIT_WIDE = 1;
    localparam int BIT_GPIO = 0;

    // Timeout select codes
    localparam logic [2:0] SEL_162US = 3'h0;
    localparam logic [2:0] SEL_325US = 3'h1;
    localparam logic [2:0] SEL_650US = 3'h2;
    localparam logic [2:0] SEL_1MS3  = 3'h3;
    localparam logic [2:0] SEL_10US  = 3'h4;
    localparam logic [2:0] SEL_20US  = 3'h5;
    localparam logic [2:0] SEL_RSVD  = 3'h6;
    localparam logic [2:0] SEL_82US  = 3'h7;

    // Timeouts in ns and their cycle counts at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_162US_NS    = 162000;
    localparam int T_325US_NS    = 325000;
    localparam int T_650US_NS    = 650000;
    localparam int T_1MS3_NS     = 1300000;
    localparam int T_10US_NS     = 10250;
    localparam int T_20US_NS     = 20500;
    localparam int T_82US_NS     = 82000;
    localparam int CNT_W         = 19;
    localparam logic [CNT_W-1:0] CYC_162US = CNT_W'(T_162US_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_325US = CNT_W'(T_325US_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_650US = CNT_W'(T_650US_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_1MS3  = CNT_W'(T_1MS3_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_10US  = CNT_W'(T_10US_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_20US  = CNT_W'(T_20US_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_82US  = CNT_W'(T_82US_NS / CLK_PERIOD_NS);

endpackage

// ===== rtl/lcdet_timer.sv
`timescale 1ns/1ps
// Quiet-time counter behind link detect
module lcdet_timer (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // Control
    input  wire logic [lcdet_pkg::CNT_W-1:0]   limit,
    input  wire logic                          run,
    input  wire logic                          restart,
    // Result
    output logic                               expired
);

    logic [lcdet_pkg::CNT_W-1:0] count_q;
    logic [lcdet_pkg::CNT_W-1:0] count_d;
    logic                        at_end;

    // Greater-or-equal so a shortened limit mid-count still expires
    assign at_end  = (count_q >= limit - lcdet_pkg::CNT_W'(1));
    assign expired = run && !restart && at_end;  // RULE8

    // Next count: fresh traffic restarts, expiry wraps
    always_comb begin
        count_d = count_q + lcdet_pkg::CNT_W'(1);
        if (!run || restart || at_end) begin
            count_d = '0;
        end
    end

    // Count register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule // lcdet_timer

// ===== verif/lcdet_remote_model.sv
`timescale 1ns/1ps
// Far-side receiver: lock level, capability beats and reverse traffic
module lcdet_remote_model (
    // Clock
    input  wire logic                         clock,
    // Control channel toward the block
    output logic                              rx_lock,
    output logic                              cap_load_valid,
    output logic [lcdet_pkg::LOAD_W-1:0]      cap_load_bits,
    output logic                              rev_valid
);
    // Idle levels from time zero
    initial begin
        rx_lock        = 1'b0;
        cap_load_valid = 1'b0;
        cap_load_bits  = '0;
        rev_valid      = 1'b0;
    end

    // Lock changes just after an edge
    task automatic set_lock(input logic v);
        @(posedge clock);
        rx_lock <= v;
    endtask

    // One capability beat; bits inverted after it so stale data never matches
    task automatic send_caps(input logic [lcdet_pkg::LOAD_W-1:0] b);
        @(posedge clock);
        cap_load_valid <= 1'b1;
        cap_load_bits  <= b;
        @(posedge clock);
        cap_load_valid <= 1'b0;
        cap_load_bits  <= ~b;
    endtask

    // One cycle of valid reverse-channel traffic
    task automatic send_beat();
        @(posedge clock);
        rev_valid <= 1'b1;
        @(posedge clock);
        rev_valid <= 1'b0;
    endtask
endmodule // lcdet_remote_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
// Register, capability and link detect checks
module tb_top;
    // Four long codes shortened; 100, 101 and 111 keep their full counts
    localparam int L_TAB [8] = '{40, 50, 60, 70, 2050, 4100, 40, 16400};
    logic       clock, rst_n, reg_wr, reg_rd, reg_rvalid, link_detect;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, caps_out;
    logic       hold, freq, eq, two, chan, wide, gpio;
    logic       rx_lock, cap_load_valid, rev_valid;
    logic [lcdet_pkg::LOAD_W-1:0] cap_load_bits;
    int         fail_count = 0;
    int         n_tests = 0;

    // Outputs gathered in register order, bit 6 always zero
    assign caps_out = {hold, 1'b0, freq, eq, two, chan, wide, gpio};

    lcdet_top #(
        .CYC_162US(19'h00028), .CYC_325US(19'h00032), .CYC_650US(19'h0003C),
        .CYC_1MS3(19'h00046)
    ) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .rx_lock(rx_lock), .cap_load_valid(cap_load_valid),
        .cap_load_bits(cap_load_bits), .rev_valid(rev_valid), .capability_hold(hold),
        .frequency_pattern_request(freq), .equalizer_pattern_request(eq),
        .two_lane_capable(two), .lane_is_secondary(chan),
        .wide_video_with_hd_audio(wide), .forward_frame_gpio_capable(gpio),
        .link_detect(link_detect)
    );

    lcdet_remote_model rm (
        .clock(clock), .rx_lock(rx_lock), .cap_load_valid(cap_load_valid),
        .cap_load_bits(cap_load_bits), .rev_valid(rev_valid)
    );

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read strobe one cycle, data checked in the cycle after
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    // Main sequence
    initial begin
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(8'h20, 8'h00);
        rdc(8'h26, 8'h00);
        rdc(8'h30, 8'h00);
        rm.send_caps(6'h3F);
        rdc(8'h20, 8'h00);
        rm.set_lock(1'b1);
        rm.send_caps(6'h2A);
        rdc(8'h20, 8'h2A);
        chk(caps_out, 8'h2A);
        rm.send_caps(6'h15);
        rdc(8'h20, 8'h15);
        chk(caps_out, 8'h15);
        wr(8'h20, 8'hFF);
        rdc(8'h20, 8'hBF);
        wr(8'h21, 8'hFF);
        rdc(8'h21, 8'h00);
        rm.send_caps(6'h00);
        rdc(8'h20, 8'hBF);
        chk(caps_out, 8'hBF);
        wr(8'h20, 8'h12);
        rdc(8'h20, 8'h12);
        rm.send_caps(6'h2D);
        rdc(8'h20, 8'h2D);
        chk(caps_out, 8'h2D);
        rm.set_lock(1'b0);
        rm.send_caps(6'h00);
        rdc(8'h20, 8'h2D);
        // Every select code, reserved upper bits written high
        for (int s = 0; s < 8; s++) begin
            wr(8'h26, 8'hF8 | 8'(s));
            rdc(8'h26, 8'(s));
            rm.send_beat();
            // Still up one edge before the count runs out
            repeat (L_TAB[s] - 1) @(posedge clock);
            #1;
            chk({7'h00, link_detect}, 8'h01);
            @(posedge clock);
            #1;
            chk({7'h00, link_detect}, 8'h00);
        end
        // Fresh traffic before expiry restarts the wait; short code again
        wr(8'h26, 8'h00);
        rm.send_beat();
        repeat (30) @(posedge clock);
        rm.send_beat();
        repeat (30) @(posedge clock);
        #1;
        chk({7'h00, link_detect}, 8'h01);
        repeat (10) @(posedge clock);
        #1;
        chk({7'h00, link_detect}, 8'h00);
        // Second reset in mid-run clears what software and the channel set
        wr(8'h26, 8'h05);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(8'h20, 8'h00);
        chk(caps_out, 8'h00);
        rdc(8'h26, 8'h00);
        report_and_stop();
    end

    // Hang guard, well beyond the roughly 23000 cycles the tests take
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
